// >>> design/logic_shift_bit_branch_exec.sv
// Operation
// - AND accumulator with literal, only null flag
// - AND accumulator with register, only null flag
// - target select 0 accumulator, 1 register
// - shift right, bit 0 into borrow flag
// - shift keeps sign bit, goes to target
// - register field 0..127, bit field 0..7
// - bit clear forces bit zero, no flags
// - bit set forces bit one, no flags
// - literal jump: incremented counter plus signed offset
// - literal jump takes two cycles
// - accumulator jump: zero-extended accumulator added, no flags
// - accumulator jump takes two cycles
// - counter change adds a discarding no-op cycle
`timescale 1ns/1ps
`default_nettype none

module logic_shift_bit_branch_exec
    import exec_pkg::*;
#(
    parameter int PCW = PC_WIDTH  // program counter width
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire exec_op_t op_code,
    input wire logic [DATA_WIDTH-1:0] imm_value,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [BITSEL_WIDTH-1:0] bit_pos,
    input wire logic dest_sel,
    input wire logic [OFFSET_WIDTH-1:0] jump_offset,
    input wire logic [DATA_WIDTH-1:0] accum_value,
    input wire logic [DATA_WIDTH-1:0] reg_rdata,
    input wire logic [PCW-1:0] pc_incr,
    output logic op_ready,
    output logic [DATA_WIDTH-1:0] accum_wdata,
    output logic accum_we,
    output logic [ADDR_WIDTH-1:0] reg_waddr,
    output logic [DATA_WIDTH-1:0] reg_wdata,
    output logic reg_we,
    output logic zero_flag,
    output logic zero_we,
    output logic carry_flag,
    output logic carry_we,
    output logic [PCW-1:0] pc_target,
    output logic pc_load,
    output logic fetch_discard
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        exec_state_t state;                // sequencer state
        logic [DATA_WIDTH-1:0] acc_data;   // accumulator write data
        logic acc_we;                      // accumulator write strobe
        logic [ADDR_WIDTH-1:0] reg_addr;   // register write address
        logic [DATA_WIDTH-1:0] reg_data;   // register write data
        logic reg_we;                      // register write strobe
        logic zero;                        // null flag value
        logic zero_we;                     // null flag write strobe
        logic carry;                       // borrow flag value
        logic carry_we;                    // borrow flag write strobe
        logic [PCW-1:0] pc;                // new counter value
        logic pc_we;                       // counter load strobe
        logic flush;                       // discard cycle marker
    } exec_regs_t;

    exec_regs_t cur;       // registered state
    exec_regs_t next_cur;  // next state

    // ------------------------------------------------------------
    // result path
    // ------------------------------------------------------------
    logic [DATA_WIDTH-1:0] alu_result;  // data result
    logic alu_carry;                    // shifted-out bit
    logic alu_zero;                     // result is zero
    logic take;                         // operation accepted this cycle
    logic [PCW-1:0] offset_ext;         // sign-extended literal offset
    logic [PCW-1:0] accum_ext;          // zero-extended accumulator

    exec_result_unit u_result (
        .op(op_code),
        .accum(accum_value),
        .operand(reg_rdata),
        .imm(imm_value),
        .bit_pos(bit_pos),
        .result(alu_result),
        .carry_out(alu_carry),
        .zero_out(alu_zero)
    );

    // handshake: refuse new work during the discard cycle
    assign op_ready = (cur.state == st_execute);
    assign take = op_valid && op_ready && clk_en;

    // offset extension for the two jump kinds
    assign offset_ext = {{(PCW-OFFSET_WIDTH){jump_offset[OFFSET_SIGN_BIT]}}, jump_offset};
    assign accum_ext = {{(PCW-DATA_WIDTH){1'b0}}, accum_value};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        // strobes last one cycle
        next_cur.acc_we = 1'b0;
        next_cur.reg_we = 1'b0;
        next_cur.zero_we = 1'b0;
        next_cur.carry_we = 1'b0;
        next_cur.pc_we = 1'b0;
        next_cur.flush = 1'b0;
        case (cur.state)
            st_execute: begin
                if (take) begin
                    case (op_code)
                        and_immediate_op: begin
                            // literal form always targets accumulator
                            next_cur.acc_data = alu_result;
                            next_cur.acc_we = 1'b1;
                            next_cur.zero = alu_zero;
                            next_cur.zero_we = 1'b1;
                        end
                        and_register_op, arith_shift_right_op: begin
                            if (dest_sel == DEST_ACCUM) begin
                                next_cur.acc_data = alu_result;
                                next_cur.acc_we = 1'b1;
                            end else begin
                                next_cur.reg_addr = reg_addr;
                                next_cur.reg_data = alu_result;
                                next_cur.reg_we = 1'b1;
                            end
                            next_cur.zero = alu_zero;
                            next_cur.zero_we = 1'b1;
                            if (op_code == arith_shift_right_op) begin
                                next_cur.carry = alu_carry;
                                next_cur.carry_we = 1'b1;
                            end
                        end
                        bit_clear_op, bit_set_op: begin
                            // write back only, no flag strobes
                            next_cur.reg_addr = reg_addr;
                            next_cur.reg_data = alu_result;
                            next_cur.reg_we = 1'b1;
                        end
                        rel_jump_literal_op: begin
                            next_cur.pc = pc_incr + offset_ext;
                            next_cur.pc_we = 1'b1;
                            next_cur.state = st_flush;
                        end
                        rel_jump_accum_op: begin
                            next_cur.pc = pc_incr + accum_ext;
                            next_cur.pc_we = 1'b1;
                            next_cur.state = st_flush;
                        end
                        default: begin
                            next_cur.state = st_execute;  // unknown code ignored
                        end
                    endcase
                end
            end
            st_flush: begin
                // second cycle executes as a no-op
                next_cur.flush = 1'b1;
                next_cur.state = st_execute;
            end
            default: begin
                next_cur.state = st_execute;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register, frozen while clock enable is low
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign accum_wdata = cur.acc_data;
    assign accum_we = cur.acc_we;
    assign reg_waddr = cur.reg_addr;
    assign reg_wdata = cur.reg_data;
    assign reg_we = cur.reg_we;
    assign zero_flag = cur.zero;
    assign zero_we = cur.zero_we;
    assign carry_flag = cur.carry;
    assign carry_we = cur.carry_we;
    assign pc_target = cur.pc;
    assign pc_load = cur.pc_we;
    assign fetch_discard = cur.flush;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_and_imm_result: assert property (
        take && op_code == and_immediate_op |=> accum_we && !reg_we && !carry_we
            && zero_we && accum_wdata == ($past(accum_value) & $past(imm_value)))
        else $error("literal and result wrong");

    chk_and_reg_flags: assert property (
        take && op_code == and_register_op |=> zero_we && !carry_we
            && (accum_we ? accum_wdata : reg_wdata) == ($past(accum_value) & $past(reg_rdata)))
        else $error("register and result wrong");

    chk_dest_select: assert property (
        take && (op_code == and_register_op || op_code == arith_shift_right_op)
            |=> (accum_we == !$past(dest_sel)) && (reg_we == $past(dest_sel)))
        else $error("target select ignored");

    chk_shift_carry: assert property (
        take && op_code == arith_shift_right_op
            |=> carry_we && carry_flag == $past(reg_rdata[0]))
        else $error("shift borrow flag wrong");

    chk_shift_sign: assert property (
        take && op_code == arith_shift_right_op && dest_sel == DEST_REG
            |=> reg_wdata == {$past(reg_rdata[SIGN_BIT]), $past(reg_rdata[DATA_WIDTH-1:1])})
        else $error("shift lost sign bit");

    chk_bit_clear: assert property (
        take && op_code == bit_clear_op |=> reg_we && !zero_we && !carry_we
            && reg_wdata == ($past(reg_rdata) & ~(8'h01 << $past(bit_pos)))
            && reg_waddr == $past(reg_addr))
        else $error("bit clear wrong");

    chk_bit_set: assert property (
        take && op_code == bit_set_op |=> reg_we && !zero_we && !carry_we
            && reg_wdata == ($past(reg_rdata) | (8'h01 << $past(bit_pos))))
        else $error("bit set wrong");

    chk_jump_literal: assert property (
        take && op_code == rel_jump_literal_op |=> pc_load && !zero_we && !carry_we
            && pc_target == PCW'($past(pc_incr) + $past(offset_ext)))
        else $error("literal jump target wrong");

    chk_jump_accum: assert property (
        take && op_code == rel_jump_accum_op |=> pc_load && !zero_we
            && pc_target == PCW'($past(pc_incr) + $past(accum_ext)))
        else $error("accumulator jump target wrong");

    chk_jump_two_cycles: assert property (
        take && (op_code == rel_jump_literal_op || op_code == rel_jump_accum_op)
            ##1 clk_en |=> fetch_discard && !accum_we && !reg_we && !pc_load)
        else $error("jump not followed by discard cycle");

    chk_flush_blocks: assert property (
        pc_load |-> !op_ready)
        else $error("work accepted during discard cycle");

    chk_zero_flag: assert property (
        zero_we |-> zero_flag == ((accum_we ? accum_wdata : reg_wdata) == ZERO_BYTE))
        else $error("null flag mismatch");

    cov_literal_jump: cover property (take && op_code == rel_jump_literal_op ##2 fetch_discard);
    cov_accum_jump: cover property (take && op_code == rel_jump_accum_op ##1 pc_load);
    cov_shift_to_reg: cover property (take && op_code == arith_shift_right_op && dest_sel);
    cov_zero_result: cover property (zero_we && zero_flag);

endmodule

`default_nettype wire

// >>> design/exec_pkg.sv
package exec_pkg;

    // ------------------------------------------------------------
    // operation codes from the decoder
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        and_immediate_op     = 3'h0,
        and_register_op      = 3'h1,
        arith_shift_right_op = 3'h2,
        bit_clear_op         = 3'h3,
        bit_set_op           = 3'h4,
        rel_jump_literal_op  = 3'h5,
        rel_jump_accum_op    = 3'h6
    } exec_op_t;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        st_execute = 1'b0,  // accepting an operation
        st_flush   = 1'b1   // forced no-operation after a jump
    } exec_state_t;

    // ------------------------------------------------------------
    // widths and field constants
    // ------------------------------------------------------------
    localparam int DATA_WIDTH = 8;       // data path width
    localparam int ADDR_WIDTH = 7;       // register operand field, 0..127
    localparam int BITSEL_WIDTH = 3;     // bit position field, 0..7
    localparam int OFFSET_WIDTH = 9;     // signed literal jump offset
    localparam int PC_WIDTH = 15;        // program counter width
    localparam int SIGN_BIT = 7;         // sign bit of the operand
    localparam int OFFSET_SIGN_BIT = 8;  // sign bit of the offset
    localparam logic DEST_ACCUM = 1'b0;  // target select: accumulator
    localparam logic DEST_REG = 1'b1;    // target select: register
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [0:0] ONE_BIT = 1'b1;
    localparam int JUMP_CYCLES = 2;      // cycles taken by a jump

endpackage

// >>> design/exec_result_unit.sv
`timescale 1ns/1ps
`default_nettype none

// combinational result path for the logic, shift and bit operations
module exec_result_unit
    import exec_pkg::*;
(
    input wire exec_op_t op,
    input wire logic [DATA_WIDTH-1:0] accum,
    input wire logic [DATA_WIDTH-1:0] operand,
    input wire logic [DATA_WIDTH-1:0] imm,
    input wire logic [BITSEL_WIDTH-1:0] bit_pos,
    output logic [DATA_WIDTH-1:0] result,
    output logic carry_out,
    output logic zero_out
);

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    logic [DATA_WIDTH-1:0] bit_mask;  // one-hot mask of the chosen bit

    always_comb begin
        bit_mask = ZERO_BYTE;
        bit_mask[bit_pos] = 1'b1;
        result = operand;
        carry_out = operand[0];
        case (op)
            and_immediate_op: begin
                result = accum & imm;
            end
            and_register_op: begin
                result = accum & operand;
            end
            arith_shift_right_op: begin
                // sign bit kept, rest moves down one place
                result = {operand[SIGN_BIT], operand[DATA_WIDTH-1:1]};
            end
            bit_clear_op: begin
                result = operand & ~bit_mask;
            end
            bit_set_op: begin
                result = operand | bit_mask;
            end
            default: begin
                result = operand;  // jumps produce no data
            end
        endcase
        zero_out = (result == ZERO_BYTE);
    end

endmodule

`default_nettype wire

// >>> verif/logic_shift_bit_branch_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module logic_shift_bit_branch_exec_tb_top;
    import exec_pkg::*;

    // ------------------------------------------------------------
    // signals and table
    // ------------------------------------------------------------
    logic clk_sys, reset_n, clk_en, op_valid, dest_sel;
    exec_op_t op_code;
    logic [DATA_WIDTH-1:0] imm_value, accum_value, reg_rdata;
    logic [ADDR_WIDTH-1:0] reg_addr;
    logic [BITSEL_WIDTH-1:0] bit_pos;
    logic [OFFSET_WIDTH-1:0] jump_offset;
    logic [PC_WIDTH-1:0] pc_incr;
    logic op_ready, accum_we, reg_we, zero_flag, zero_we, carry_flag, carry_we;
    logic pc_load, fetch_discard;
    logic [DATA_WIDTH-1:0] accum_wdata, reg_wdata;
    logic [ADDR_WIDTH-1:0] reg_waddr;
    logic [PC_WIDTH-1:0] pc_target;
    int n_mismatch = 0; // failed comparisons
    int checks_done = 0; // all comparisons
    int cycles = 0; // hang guard

    // one case: inputs, then expected result, flags and counter
    typedef struct {
        exec_op_t op;
        logic [7:0] acc, opnd;
        logic [6:0] addr;
        logic [2:0] bp;
        logic d;
        logic [8:0] off;
        logic [14:0] pc;
        logic [7:0] res;
        logic z, c;
        logic [14:0] pct;
    } row_t;
    row_t rows [16];

    logic_shift_bit_branch_exec #(.PCW(PC_WIDTH)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
        .op_code(op_code), .imm_value(imm_value), .reg_addr(reg_addr), .bit_pos(bit_pos),
        .dest_sel(dest_sel), .jump_offset(jump_offset), .accum_value(accum_value),
        .reg_rdata(reg_rdata), .pc_incr(pc_incr), .op_ready(op_ready),
        .accum_wdata(accum_wdata), .accum_we(accum_we), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .zero_flag(zero_flag), .zero_we(zero_we),
        .carry_flag(carry_flag), .carry_we(carry_we), .pc_target(pc_target),
        .pc_load(pc_load), .fetch_discard(fetch_discard)
    );

    // ------------------------------------------------------------
    // clock, hang guard, helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // cut a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // present a row; the unused operand source gets the inverse value
    task automatic drive(input row_t r);
        op_code = r.op;
        accum_value = r.acc;
        imm_value = (r.op == and_immediate_op) ? r.opnd : ~r.opnd;
        reg_rdata = (r.op == and_immediate_op) ? ~r.opnd : r.opnd;
        reg_addr = r.addr;
        bit_pos = r.bp;
        dest_sel = r.d;
        jump_offset = r.off;
        pc_incr = r.pc;
        op_valid = 1'b1;
    endtask

    // strobes and data in the cycle after the taking edge
    task automatic expect_row(input row_t r);
        logic rop, jmp, awe, rwe;
        rop = (r.op == and_register_op) || (r.op == arith_shift_right_op);
        jmp = (r.op == rel_jump_literal_op) || (r.op == rel_jump_accum_op);
        awe = (r.op == and_immediate_op) || (rop && !r.d);
        rwe = (r.op == bit_clear_op) || (r.op == bit_set_op) || (rop && r.d);
        check("accum_we", accum_we, awe);
        check("reg_we", reg_we, rwe);
        check("zero_we", zero_we, (r.op == and_immediate_op) || rop);
        check("carry_we", carry_we, r.op == arith_shift_right_op);
        check("pc_load", pc_load, jmp);
        if (awe) check("accum_wdata", accum_wdata, r.res);
        if (rwe) check("reg_wdata", reg_wdata, r.res);
        if (rwe) check("reg_waddr", reg_waddr, r.addr);
        if (zero_we) check("zero_flag", zero_flag, r.z);
        if (carry_we) check("carry_flag", carry_flag, r.c);
        if (jmp) check("pc_target", pc_target, r.pct);
        check("op_ready", op_ready, !jmp);
    endtask

    task automatic run_row(input row_t r);
        @(negedge clk_sys);
        drive(r);
        check("op_ready", op_ready, 1'b1);
        @(negedge clk_sys);
        op_valid = 1'b0;
        expect_row(r);
        @(negedge clk_sys);
        check("fetch_discard", fetch_discard,
              (r.op == rel_jump_literal_op) || (r.op == rel_jump_accum_op));
        check("pc_load", pc_load, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{
            '{and_immediate_op, 8'hf0, 8'h3c, 7'h00, 3'h0, 1'b0, 9'h000, 15'h0, 8'h30, 1'b0, 1'b0, 15'h0},
            '{and_immediate_op, 8'haa, 8'h55, 7'h00, 3'h0, 1'b1, 9'h000, 15'h0, 8'h00, 1'b1, 1'b0, 15'h0},
            '{and_register_op, 8'h0f, 8'hff, 7'h7f, 3'h0, 1'b0, 9'h000, 15'h0, 8'h0f, 1'b0, 1'b0, 15'h0},
            '{and_register_op, 8'h81, 8'h80, 7'h00, 3'h0, 1'b1, 9'h000, 15'h0, 8'h80, 1'b0, 1'b0, 15'h0},
            '{and_register_op, 8'h0f, 8'hf0, 7'h55, 3'h0, 1'b1, 9'h000, 15'h0, 8'h00, 1'b1, 1'b0, 15'h0},
            '{arith_shift_right_op, 8'h00, 8'h81, 7'h10, 3'h0, 1'b0, 9'h000, 15'h0, 8'hc0, 1'b0, 1'b1, 15'h0},
            '{arith_shift_right_op, 8'hff, 8'h01, 7'h12, 3'h0, 1'b1, 9'h000, 15'h0, 8'h00, 1'b1, 1'b1, 15'h0},
            '{arith_shift_right_op, 8'h00, 8'h7e, 7'h40, 3'h0, 1'b1, 9'h000, 15'h0, 8'h3f, 1'b0, 1'b0, 15'h0},
            '{bit_clear_op, 8'h00, 8'hff, 7'h7f, 3'h7, 1'b0, 9'h000, 15'h0, 8'h7f, 1'b0, 1'b0, 15'h0},
            '{bit_set_op, 8'hff, 8'h00, 7'h01, 3'h0, 1'b0, 9'h000, 15'h0, 8'h01, 1'b0, 1'b0, 15'h0},
            '{bit_clear_op, 8'h00, 8'h5a, 7'h22, 3'h3, 1'b1, 9'h000, 15'h0, 8'h52, 1'b0, 1'b0, 15'h0},
            '{bit_set_op, 8'h00, 8'ha5, 7'h33, 3'h6, 1'b0, 9'h000, 15'h0, 8'he5, 1'b0, 1'b0, 15'h0},
            '{rel_jump_literal_op, 8'hff, 8'h00, 7'h00, 3'h0, 1'b0, 9'h100, 15'h0100, 8'h00, 1'b0, 1'b0, 15'h0000},
            '{rel_jump_literal_op, 8'hff, 8'h00, 7'h00, 3'h0, 1'b0, 9'h0ff, 15'h7fff, 8'h00, 1'b0, 1'b0, 15'h00fe},
            '{rel_jump_accum_op, 8'hff, 8'h00, 7'h00, 3'h0, 1'b0, 9'h1ff, 15'h1000, 8'h00, 1'b0, 1'b0, 15'h10ff},
            '{rel_jump_accum_op, 8'h80, 8'h00, 7'h00, 3'h0, 1'b0, 9'h000, 15'h7f90, 8'h00, 1'b0, 1'b0, 15'h0010}
        };
        {reset_n, op_valid, dest_sel, imm_value, accum_value, reg_rdata} = '0;
        {reg_addr, bit_pos, jump_offset, pc_incr} = '0;
        op_code = and_immediate_op;
        clk_en = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("op_ready", op_ready, 1'b1);
        check("strobes", {accum_we, reg_we, zero_we, carry_we, pc_load, fetch_discard}, 0);
        reset_n = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // back to back: and literal then bit set
        @(negedge clk_sys);
        drive(rows[0]);
        @(negedge clk_sys);
        expect_row(rows[0]);
        drive(rows[11]);
        @(negedge clk_sys);
        op_valid = 1'b0;
        expect_row(rows[11]);
        // offer during the discard cycle is refused
        @(negedge clk_sys);
        drive(rows[12]);
        @(negedge clk_sys);
        expect_row(rows[12]);
        drive(rows[0]);
        @(negedge clk_sys);
        op_valid = 1'b0;
        check("fetch_discard", fetch_discard, 1'b1);
        check("accum_we", accum_we, 1'b0);
        @(negedge clk_sys);
        check("accum_we", accum_we, 1'b0);
        // clock enable low holds the offer back
        drive(rows[1]);
        clk_en = 1'b0;
        @(negedge clk_sys);
        check("accum_we", accum_we, 1'b0);
        clk_en = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        expect_row(rows[1]);
        // unknown code taken with no effect
        @(negedge clk_sys);
        drive(rows[3]);
        op_code = exec_op_t'(3'h7);
        @(negedge clk_sys);
        op_valid = 1'b0;
        check("strobes", {accum_we, reg_we, zero_we, carry_we, pc_load}, 0);
        // reset in mid-jump clears the pulse
        @(negedge clk_sys);
        drive(rows[14]);
        @(negedge clk_sys);
        op_valid = 1'b0;
        check("pc_load", pc_load, 1'b1);
        #1 reset_n = 1'b0;
        #1 check("pc_load", pc_load, 1'b0);
        check("op_ready", op_ready, 1'b1);
        @(negedge clk_sys);
        reset_n = 1'b1;
        run_row(rows[5]);
        close_out();
    end

endmodule

`default_nettype wire
